// file: hdl/sbfw_dev.sv
// device end: boot-mode flash-write protocol engine
`timescale 1ns/1ps
`include "sbfw_params.svh"
module sbfw_dev (
  input  wire logic                           CLK_SYS,
  input  wire logic                           RSTN,
  sbfw_link_if.dev                            bus,
  input  wire logic [8*`SBFW_RATE_SLOTS-1:0]  RATE_CODES,
  input  wire logic                           BLANK,
  input  wire logic                           READ_PROT,
  output logic      [15:0]                    MEM_ADDR,
  input  wire logic [7:0]                     MEM_RDATA,
  output logic                                WR_VALID,
  output logic      [15:0]                    WR_ADDR,
  output logic      [7:0]                     WR_DATA,
  output logic      [7:0]                     LINK_RATE,
  output logic                                RATE_UPDATE,
  output logic                                HALTED
);

  localparam sbfw_pkg::sbfw_dev_state_t DevRst = '{
    st: sbfw_pkg::D_MATCH, rate: `SBFW_RATE_DEF, default: '0};

  sbfw_pkg::sbfw_dev_state_t s;
  sbfw_pkg::sbfw_dev_state_t n;
  logic [`SBFW_RATE_SLOTS-1:0] rate_hit;

  // one comparator per rate code valid at this operating frequency
  for (genvar i = 0; i < `SBFW_RATE_SLOTS; i++) begin : g_rate
    assign rate_hit[i] = (bus.h2d_data == RATE_CODES[i*8 +: 8]);
  end

  // link side of the two-entry reply buffer
  assign bus.d2h_valid = (s.fq_cnt != 2'h0);
  assign bus.d2h_data  = s.fq[s.fq_rp];
  assign bus.h2d_ready = s.rx_rdy;
  assign bus.rate      = s.rate;

  // user outputs straight from the state register
  assign MEM_ADDR    = s.mem_addr;
  assign WR_VALID    = s.wr_valid;
  assign WR_ADDR     = s.wr_addr;
  assign WR_DATA     = s.wr_data;
  assign LINK_RATE   = s.rate;
  assign RATE_UPDATE = s.rate_pulse;
  assign HALTED      = s.halted;

  // next-state of the whole engine
  always_comb begin
    logic       take;
    logic       bad;
    logic       pop;
    logic       push;
    logic [7:0] pbyte;
    logic [7:0] b;
    logic [7:0] rsum;
    n     = s;
    take  = bus.h2d_valid && s.rx_rdy;
    bad   = bus.h2d_err;
    b     = bus.h2d_data;
    pop   = (s.fq_cnt != 2'h0) && bus.d2h_ready;
    push  = 1'b0;
    pbyte = 8'h00;
    rsum  = s.rec_sum + b;
    n.rate_pulse = 1'b0;
    n.wr_valid   = 1'b0;
    case (s.st)
      sbfw_pkg::D_MATCH: begin
        // a corrupt or wrong byte is simply not recognised; keep hunting
        if (take && !bad && b == `SBFW_MATCH) begin
          push  = 1'b1;
          pbyte = `SBFW_MATCH;
          n.st  = sbfw_pkg::D_RATE;
        end
      end
      sbfw_pkg::D_RATE: begin
        if (take) begin
          if (!bad && (|rate_hit)) begin
            push        = 1'b1;
            pbyte       = b;
            n.rate_pend = b;
            n.st        = sbfw_pkg::D_RATE_APPLY;
          end else begin
            n.err_code = `SBFW_ERR_RATE;
            n.err_idx  = 4'h0;
            n.st       = sbfw_pkg::D_ERR;
          end
        end
      end
      sbfw_pkg::D_RATE_APPLY: begin
        // switching before the echo leaves would garble it at the far end
        if (s.fq_cnt == 2'h0) begin
          n.rate       = s.rate_pend;
          n.rate_pulse = 1'b1;
          n.st         = sbfw_pkg::D_CMD;
        end
      end
      sbfw_pkg::D_CMD: begin
        if (take) begin
          if (bad || b != `SBFW_CMD_WRITE) begin
            n.err_code = `SBFW_ERR_CMD;
            n.err_idx  = 4'h0;
            n.st       = sbfw_pkg::D_ERR;
          end else if (READ_PROT) begin
            n.st = sbfw_pkg::D_HALT;
          end else begin
            push   = 1'b1;
            pbyte  = b;
            n.idx  = 8'h00;
            n.xsum = 16'h0000;
            n.st   = sbfw_pkg::D_PADDR;
          end
        end
      end
      sbfw_pkg::D_PADDR: begin
        if (take) begin
          if (bad) begin
            n.st = sbfw_pkg::D_HALT;
          end else begin
            case (s.idx[1:0])
              2'h0: n.cnt_addr[15:8] = b;
              2'h1: n.cnt_addr[7:0]  = b;
              2'h2: n.pw_addr[15:8]  = b;
              default: n.pw_addr[7:0] = b;
            endcase
            n.idx = s.idx + 8'h01;
            if (s.idx == `SBFW_ADDR_LAST) begin
              n.mem_addr = s.cnt_addr;
              n.st       = sbfw_pkg::D_CNT_RD;
            end
          end
        end
      end
      sbfw_pkg::D_CNT_RD: begin
        // an empty count or a string running past the top is a bad address
        n.pw_cnt   = MEM_RDATA;
        n.idx      = 8'h00;
        n.mem_addr = s.pw_addr;
        if (MEM_RDATA == 8'h00 ||
            ({1'b0, s.pw_addr} + {9'h000, MEM_RDATA}) > `SBFW_ADDR_TOP) begin
          n.st = sbfw_pkg::D_HALT;
        end else if (BLANK) begin
          n.st = sbfw_pkg::D_HUNT;
        end else begin
          n.st = sbfw_pkg::D_PW;
        end
      end
      sbfw_pkg::D_PW: begin
        if (take) begin
          if (bad || b != MEM_RDATA) begin
            n.st = sbfw_pkg::D_HALT;
          end else begin
            n.idx      = s.idx + 8'h01;
            n.mem_addr = s.mem_addr + 16'h0001;
            if (s.idx + 8'h01 == s.pw_cnt) begin
              n.st = sbfw_pkg::D_HUNT;
            end
          end
        end
      end
      sbfw_pkg::D_HUNT: begin
        if (take && bad) begin
          n.st = sbfw_pkg::D_HALT;
        end else if (take && b == `SBFW_REC_MARK) begin
          n.rec_sum = 8'h00;
          n.st      = sbfw_pkg::D_LEN;
        end
      end
      sbfw_pkg::D_LEN, sbfw_pkg::D_AHI, sbfw_pkg::D_ALO, sbfw_pkg::D_TYPE,
      sbfw_pkg::D_DATA, sbfw_pkg::D_CKS: begin
        if (take && bad) begin
          n.st = sbfw_pkg::D_HALT;
        end else if (take) begin
          n.rec_sum = rsum;
          case (s.st)
            sbfw_pkg::D_LEN: begin
              n.rec_len = b;
              n.rec_idx = 8'h00;
              n.st      = sbfw_pkg::D_AHI;
            end
            sbfw_pkg::D_AHI: begin
              n.rec_addr[15:8] = b;
              n.st             = sbfw_pkg::D_ALO;
            end
            sbfw_pkg::D_ALO: begin
              n.rec_addr[7:0] = b;
              n.st            = sbfw_pkg::D_TYPE;
            end
            sbfw_pkg::D_TYPE: begin
              n.rec_type = b;
              if (b == `SBFW_REC_DATA && s.rec_len != 8'h00) begin
                n.st = sbfw_pkg::D_DATA;
              end else if (b == `SBFW_REC_DATA || 
                           (b == `SBFW_REC_END && s.rec_len == 8'h00)) begin
                n.st = sbfw_pkg::D_CKS;
              end else begin
                n.st = sbfw_pkg::D_HALT;
              end
            end
            sbfw_pkg::D_DATA: begin
              n.wr_valid = 1'b1;
              n.wr_addr  = s.rec_addr + {8'h00, s.rec_idx};
              n.wr_data  = b;
              n.xsum     = s.xsum + {8'h00, b};
              n.rec_idx  = s.rec_idx + 8'h01;
              if (s.rec_idx + 8'h01 == s.rec_len) begin
                n.st = sbfw_pkg::D_CKS;
              end
            end
            default: begin
              // record bytes including its checksum must sum to zero
              if (rsum != 8'h00) begin
                n.st = sbfw_pkg::D_HALT;
              end else if (s.rec_type == `SBFW_REC_END) begin
                n.st = sbfw_pkg::D_SUM_HI;
              end else begin
                n.st = sbfw_pkg::D_HUNT;
              end
            end
          endcase
        end
      end
      sbfw_pkg::D_SUM_HI: begin
        if (s.fq_cnt != `SBFW_FIFO_FULL) begin
          push  = 1'b1;
          pbyte = s.xsum[15:8];
          n.st  = sbfw_pkg::D_SUM_LO;
        end
      end
      sbfw_pkg::D_SUM_LO: begin
        if (s.fq_cnt != `SBFW_FIFO_FULL) begin
          push  = 1'b1;
          pbyte = s.xsum[7:0];
          n.st  = sbfw_pkg::D_CMD;
        end
      end
      sbfw_pkg::D_ERR: begin
        // nine error bytes trickle out as the buffer drains
        if (s.fq_cnt != `SBFW_FIFO_FULL) begin
          push      = 1'b1;
          pbyte     = (s.err_idx < `SBFW_ERR_MID_AT)  ? `SBFW_ERR_LEAD :
                      (s.err_idx < `SBFW_ERR_CODE_AT) ? `SBFW_ERR_MID  : s.err_code;
          n.err_idx = s.err_idx + 4'h1;
          if (s.err_idx + 4'h1 == `SBFW_ERR_LAST + 4'h1) begin
            n.st = sbfw_pkg::D_HALT;
          end
        end
      end
      default: begin
        n.halted = 1'b1;
      end
    endcase
    if (push) begin
      n.fq[s.fq_wp] = pbyte;
      n.fq_wp       = ~s.fq_wp;
    end
    if (pop) begin
      n.fq_rp = ~s.fq_rp;
    end
    n.fq_cnt = s.fq_cnt + {1'b0, push} - {1'b0, pop};
    // receive only with room for a reply; halt keeps draining and drops
    n.rx_rdy = (n.fq_cnt != `SBFW_FIFO_FULL) &&
               (n.st != sbfw_pkg::D_RATE_APPLY) && (n.st != sbfw_pkg::D_CNT_RD) &&
               (n.st != sbfw_pkg::D_ERR) && (n.st != sbfw_pkg::D_SUM_HI) &&
               (n.st != sbfw_pkg::D_SUM_LO);
  end

  // single state register
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s <= DevRst;
    end else begin
      s <= n;
    end
  end

endmodule

// file: pkg/sbfw_params.svh
// constants of the serial boot flash-write protocol engine
`ifndef SBFW_PARAMS_SVH
`define SBFW_PARAMS_SVH

`define SBFW_CLK_MHZ      100
`define SBFW_SYNC_WAIT_US 20
`define SBFW_MATCH        8'h5a
`define SBFW_RATE_DEF     8'h28
`define SBFW_CMD_WRITE    8'h30
`define SBFW_ERR_LEAD     8'ha1
`define SBFW_ERR_MID      8'ha3
`define SBFW_ERR_RATE     8'h62
`define SBFW_ERR_CMD      8'h63
`define SBFW_REC_MARK     8'h3a
`define SBFW_REC_DATA     8'h00
`define SBFW_REC_END      8'h01
`define SBFW_ERR_MID_AT   4'h3
`define SBFW_ERR_CODE_AT  4'h6
`define SBFW_ERR_LAST     4'h8
`define SBFW_ADDR_LAST    8'h03
`define SBFW_ADDR_TOP     17'h10000
`define SBFW_RATE_SLOTS   5
`define SBFW_FIFO_FULL    2'h2

`endif

// file: pkg/sbfw_pkg.sv
// types shared by both ends of the serial boot flash-write link
`include "sbfw_params.svh"
package sbfw_pkg;

  typedef enum logic [4:0] {
    D_MATCH, D_RATE, D_RATE_APPLY, D_CMD, D_PADDR, D_CNT_RD, D_PW, D_HUNT,
    D_LEN, D_AHI, D_ALO, D_TYPE, D_DATA, D_CKS, D_SUM_HI, D_SUM_LO, D_ERR, D_HALT
  } sbfw_dev_st_t;

  typedef enum logic [3:0] {
    H_IDLE, H_SYNC, H_SYNC_WAIT, H_RATE, H_RATE_WAIT, H_CMD, H_CMD_WAIT,
    H_ADDR, H_PW, H_REC, H_SUM_HI, H_SUM_LO, H_FAIL
  } sbfw_host_st_t;

  typedef struct packed {
    sbfw_dev_st_t    st;
    logic            rx_rdy;
    logic            halted;
    logic [7:0]      rate;
    logic [7:0]      rate_pend;
    logic            rate_pulse;
    logic [15:0]     cnt_addr;
    logic [15:0]     pw_addr;
    logic [15:0]     mem_addr;
    logic [7:0]      pw_cnt;
    logic [7:0]      idx;
    logic [7:0]      rec_len;
    logic [7:0]      rec_idx;
    logic [7:0]      rec_type;
    logic [7:0]      rec_sum;
    logic [15:0]     rec_addr;
    logic [15:0]     xsum;
    logic            wr_valid;
    logic [15:0]     wr_addr;
    logic [7:0]      wr_data;
    logic [7:0]      err_code;
    logic [3:0]      err_idx;
    logic [1:0][7:0] fq;
    logic            fq_wp;
    logic            fq_rp;
    logic [1:0]      fq_cnt;
  } sbfw_dev_state_t;

  typedef struct packed {
    sbfw_host_st_t st;
    logic          tx_valid;
    logic [7:0]    tx_data;
    logic          rx_rdy;
    logic          pw_rdy;
    logic          rec_rdy;
    logic [15:0]   timer;
    logic [7:0]    idx;
    logic          busy;
    logic          done;
    logic          fail;
    logic          sum_valid;
    logic [15:0]   sum;
  } sbfw_host_state_t;

endpackage

// file: pkg/sbfw_link_if.sv
// byte link between the external programming controller and the device
`timescale 1ns/1ps
interface sbfw_link_if;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] h2d_data;
  logic       h2d_err;
  logic       d2h_valid;
  logic       d2h_ready;
  logic [7:0] d2h_data;
  logic [7:0] rate;

  modport dev (
    input  h2d_valid, h2d_data, h2d_err, d2h_ready,
    output h2d_ready, d2h_valid, d2h_data, rate
  );
  modport host (
    output h2d_valid, h2d_data, h2d_err, d2h_ready,
    input  h2d_ready, d2h_valid, d2h_data, rate
  );
endinterface

// file: hdl/sbfw_host.sv
// controller end: drives one flash-write session over the byte link
`timescale 1ns/1ps
`include "sbfw_params.svh"
module sbfw_host (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  sbfw_link_if.host        bus,
  input  wire logic        START,
  input  wire logic        SKIP_SYNC,
  input  wire logic [7:0]  RATE_CODE,
  input  wire logic [15:0] CNT_ADDR,
  input  wire logic [15:0] PW_ADDR,
  input  wire logic [7:0]  PW_LEN,
  input  wire logic        PW_VALID,
  input  wire logic [7:0]  PW_DATA,
  output logic             PW_READY,
  input  wire logic        REC_VALID,
  input  wire logic [7:0]  REC_DATA,
  input  wire logic        REC_LAST,
  output logic             REC_READY,
  output logic             BUSY,
  output logic             DONE,
  output logic             FAIL,
  output logic             SUM_VALID,
  output logic [15:0]      SUM
);

  localparam int SyncWaitCyc = `SBFW_SYNC_WAIT_US * `SBFW_CLK_MHZ;
  localparam sbfw_pkg::sbfw_host_state_t HostRst = '{
    st: sbfw_pkg::H_IDLE, default: '0};

  sbfw_pkg::sbfw_host_state_t s;
  sbfw_pkg::sbfw_host_state_t n;

  assign bus.h2d_valid = s.tx_valid;
  assign bus.h2d_data  = s.tx_data;
  assign bus.h2d_err   = 1'b0;
  assign bus.d2h_ready = s.rx_rdy;
  assign PW_READY      = s.pw_rdy;
  assign REC_READY     = s.rec_rdy;
  assign BUSY          = s.busy;
  assign DONE          = s.done;
  assign FAIL          = s.fail;
  assign SUM_VALID     = s.sum_valid;
  assign SUM           = s.sum;

  // next-state of the session sequencer
  always_comb begin
    logic       got;
    logic       free;
    logic [7:0] r;
    n           = s;
    got         = bus.d2h_valid && s.rx_rdy;
    r           = bus.d2h_data;
    free        = !s.tx_valid;
    n.done      = 1'b0;
    n.sum_valid = 1'b0;
    n.rx_rdy    = 1'b1;
    if (s.tx_valid && bus.h2d_ready) begin
      n.tx_valid = 1'b0;
    end
    case (s.st)
      sbfw_pkg::H_IDLE, sbfw_pkg::H_FAIL: begin
        if (START) begin
          n.fail = 1'b0;
          n.busy = 1'b1;
          n.st   = SKIP_SYNC ? sbfw_pkg::H_CMD : sbfw_pkg::H_SYNC;
        end
      end
      sbfw_pkg::H_SYNC: begin
        if (free) begin
          n.tx_valid = 1'b1;
          n.tx_data  = `SBFW_MATCH;
          n.timer    = 16'(SyncWaitCyc);
          n.st       = sbfw_pkg::H_SYNC_WAIT;
        end
      end
      sbfw_pkg::H_SYNC_WAIT: begin
        n.timer = s.timer - 16'h0001;
        if (got && r == `SBFW_MATCH) begin
          n.st = sbfw_pkg::H_RATE;
        end else if (s.timer == 16'h0000) begin
          n.st = sbfw_pkg::H_SYNC;
        end
      end
      sbfw_pkg::H_RATE: begin
        if (free) begin
          n.tx_valid = 1'b1;
          n.tx_data  = RATE_CODE;
          n.st       = sbfw_pkg::H_RATE_WAIT;
        end
      end
      sbfw_pkg::H_RATE_WAIT: begin
        if (got) begin
          n.st = (r == RATE_CODE) ? sbfw_pkg::H_CMD : sbfw_pkg::H_FAIL;
        end
      end
      sbfw_pkg::H_CMD: begin
        if (free) begin
          n.tx_valid = 1'b1;
          n.tx_data  = `SBFW_CMD_WRITE;
          n.st       = sbfw_pkg::H_CMD_WAIT;
        end
      end
      sbfw_pkg::H_CMD_WAIT: begin
        if (got) begin
          n.idx = 8'h00;
          n.st  = (r == `SBFW_CMD_WRITE) ? sbfw_pkg::H_ADDR : sbfw_pkg::H_FAIL;
        end
      end
      sbfw_pkg::H_ADDR: begin
        // both addresses go out even for a blank part
        if (free) begin
          n.tx_valid = 1'b1;
          case (s.idx[1:0])
            2'h0: n.tx_data = CNT_ADDR[15:8];
            2'h1: n.tx_data = CNT_ADDR[7:0];
            2'h2: n.tx_data = PW_ADDR[15:8];
            default: n.tx_data = PW_ADDR[7:0];
          endcase
          n.idx = s.idx + 8'h01;
          if (s.idx == `SBFW_ADDR_LAST) begin
            n.idx = 8'h00;
            n.st  = (PW_LEN == 8'h00) ? sbfw_pkg::H_REC : sbfw_pkg::H_PW;
          end
        end
      end
      sbfw_pkg::H_PW: begin
        if (PW_VALID && s.pw_rdy) begin
          n.tx_valid = 1'b1;
          n.tx_data  = PW_DATA;
          n.idx      = s.idx + 8'h01;
          if (s.idx + 8'h01 == PW_LEN) begin
            n.st = sbfw_pkg::H_REC;
          end
        end
      end
      sbfw_pkg::H_REC: begin
        if (REC_VALID && s.rec_rdy) begin
          n.tx_valid = 1'b1;
          n.tx_data  = REC_DATA;
          if (REC_LAST) begin
            n.st = sbfw_pkg::H_SUM_HI;
          end
        end
      end
      sbfw_pkg::H_SUM_HI: begin
        if (got) begin
          n.sum[15:8] = r;
          n.st        = sbfw_pkg::H_SUM_LO;
        end
      end
      default: begin
        if (got) begin
          n.sum[7:0]  = r;
          n.sum_valid = 1'b1;
          n.done      = 1'b1;
          n.busy      = 1'b0;
          n.st        = sbfw_pkg::H_IDLE;
        end
      end
    endcase
    if (n.st == sbfw_pkg::H_FAIL && s.st != sbfw_pkg::H_FAIL) begin
      n.fail = 1'b1;
      n.busy = 1'b0;
    end
    // user streams are offered only while the send register is empty
    n.pw_rdy  = (n.st == sbfw_pkg::H_PW) && !n.tx_valid;
    n.rec_rdy = (n.st == sbfw_pkg::H_REC) && !n.tx_valid;
  end

  // single state register
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      s <= HostRst;
    end else begin
      s <= n;
    end
  end

endmodule

// file: tb/sbfw_link_monitor.sv
// assertions on the byte link between controller and device
`timescale 1ns/1ps
module sbfw_link_monitor (
  input wire logic       CLK_SYS,
  input wire logic       RSTN,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_err,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready,
  input wire logic [7:0] d2h_data,
  input wire logic [7:0] rate
);
  logic [3:0] nb;
  logic [3:0] nr;
  logic       tk;
  assign tk = h2d_valid && h2d_ready;
  // saturating byte counts never wrap back into the early phases
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      nb <= 4'h0;
      nr <= 4'h0;
    end else begin
      nb <= (tk && nb != 4'hf) ? nb + 4'h1 : nb;
      nr <= (d2h_valid && d2h_ready && nr != 4'hf) ? nr + 4'h1 : nr;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  match_echo_a: assert property (tk && nb == 4'h0 && h2d_data == 8'h5a
    |=> d2h_valid && d2h_data == 8'h5a) else $error("no match echo");
  rate_init_a: assert property (nb < 4'h2 |-> rate == 8'h28)
    else $error("rate left initial value early");
  rate_echo_a: assert property (tk && nb == 4'h1
    |=> d2h_valid && d2h_data == $past(h2d_data)) else $error("no rate echo");
  rate_late_a: assert property (!$stable(rate) |-> nr == 4'h2 && !d2h_valid)
    else $error("rate switched before echo sent");
  cmd_echo_a: assert property (tk && nb == 4'h2
    |=> d2h_valid && d2h_data == 8'h30) else $error("no command echo");
  addr_quiet_a: assert property (tk && nb >= 4'h3 && nb <= 4'h6
    |=> !d2h_valid [*3]) else $error("reply to address byte");
  rec_quiet_a: assert property (tk && nb >= 4'h7 && nb <= 4'he
    |=> !d2h_valid [*2]) else $error("reply to password or record byte");
  sum_pair_a: assert property (d2h_valid && d2h_ready && nr == 4'h3
    |-> ##[1:21] (d2h_valid && d2h_ready)) else $error("checksum low byte missing");
  next_cmd_a: assert property (d2h_valid && nr == 4'h5 |-> d2h_data == 8'h30)
    else $error("second command not echoed");
endmodule

// file: tb/tb.sv
// self-checking bench: controller against device, plus a device driven directly
`timescale 1ns/1ps
module tb;
  logic        CLK_SYS = 1'b0;
  logic        RSTN = 1'b0;
  logic        rstn_b = 1'b0;
  logic        start = 1'b0;
  logic        skip_sync = 1'b0;
  logic [7:0]  rate_code = 8'h18;
  logic [7:0]  pw_len = 8'h00;
  logic        pw_valid = 1'b0;
  logic [7:0]  pw_data = 8'h00;
  logic        rec_valid = 1'b0;
  logic [7:0]  rec_data = 8'h00;
  logic        rec_last = 1'b0;
  logic        blank = 1'b0;
  logic        blank_b = 1'b0;
  logic        prot_b = 1'b0;
  logic        pw_ready, rec_ready, fail, sum_valid, wr_valid, halted_b;
  logic        done, busy, halted, rate_upd;
  logic [15:0] sum, mem_addr, mem_addr_b, wr_addr;
  logic [7:0]  wr_data, link_rate;
  logic [23:0] wq[$];
  int          n_fail = 0;
  int          total_checks = 0;
  int          n_upd = 0;
  sbfw_link_if link();
  sbfw_link_if link_b();

  always #5 CLK_SYS = ~CLK_SYS;

  // stored bytes: count 3 at 0010h, count 0 at 0011h, password 31h.. from 0020h
  function automatic logic [7:0] mem(input logic [15:0] a);
    return (a == 16'h0010) ? 8'h03 : (a == 16'h0011) ? 8'h00 : a[7:0] + 8'h11;
  endfunction

  sbfw_host u_sbfw_host (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .bus(link.host), .START(start),
    .SKIP_SYNC(skip_sync), .RATE_CODE(rate_code), .CNT_ADDR(16'h0010), .PW_ADDR(16'h0020),
    .PW_LEN(pw_len), .PW_VALID(pw_valid), .PW_DATA(pw_data), .PW_READY(pw_ready),
    .REC_VALID(rec_valid), .REC_DATA(rec_data), .REC_LAST(rec_last), .REC_READY(rec_ready),
    .BUSY(busy), .DONE(done), .FAIL(fail), .SUM_VALID(sum_valid), .SUM(sum));
  sbfw_dev u_sbfw_dev (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .bus(link.dev),
    .RATE_CODES(40'h4840382818), .BLANK(blank), .READ_PROT(1'b0), .MEM_ADDR(mem_addr),
    .MEM_RDATA(mem(mem_addr)), .WR_VALID(wr_valid), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
    .LINK_RATE(link_rate), .RATE_UPDATE(rate_upd), .HALTED(halted));
  // second device, faced by the bench so that faults can be injected
  sbfw_dev u_sbfw_dev2 (.CLK_SYS(CLK_SYS), .RSTN(rstn_b), .bus(link_b.dev),
    .RATE_CODES(40'h4840382818), .BLANK(blank_b), .READ_PROT(prot_b), .MEM_ADDR(mem_addr_b),
    .MEM_RDATA(mem(mem_addr_b)), .WR_VALID(), .WR_ADDR(), .WR_DATA(), .LINK_RATE(),
    .RATE_UPDATE(), .HALTED(halted_b));
  sbfw_link_monitor u_sbfw_link_monitor (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
    .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready), .h2d_data(link.h2d_data),
    .h2d_err(link.h2d_err), .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready),
    .d2h_data(link.d2h_data), .rate(link.rate));

  // collect flash writes and rate updates of the first device
  always @(posedge CLK_SYS) begin
    if (wr_valid === 1'b1) wq.push_back({wr_addr, wr_data});
    if (rate_upd === 1'b1) n_upd++;
  end

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done;
    if (n_fail == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic stuck(input string what);
    check(what, 24'h1, 24'h0);
    test_done;
  endtask

  // offer one byte; ready is a register, so its negedge value holds at the edge
  task automatic push(input logic pw, input logic [7:0] d, input logic last);
    int i;
    @(negedge CLK_SYS);
    pw_valid = pw;
    rec_valid = !pw;
    pw_data = d;
    rec_data = d;
    rec_last = last;
    for (i = 0; i < 5000 && (pw ? pw_ready : rec_ready) !== 1'b1; i++) @(negedge CLK_SYS);
    if (i == 5000) stuck("stream ready");
    @(posedge CLK_SYS);
  endtask

  task automatic session(input logic sk, input logic [7:0] pl, input logic [7:0] r[$],
                         input logic [15:0] es);
    int i;
    @(negedge CLK_SYS);
    skip_sync = sk;
    pw_len = pl;
    start = 1'b1;
    @(negedge CLK_SYS);
    start = 1'b0;
    for (i = 0; i < pl; i++) push(1'b1, 8'h31 + i[7:0], 1'b0);
    for (i = 0; i < r.size(); i++) push(1'b0, r[i], i == r.size() - 1);
    @(negedge CLK_SYS);
    pw_valid = 1'b0;
    rec_valid = 1'b0;
    rec_last = 1'b0;
    for (i = 0; i < 5000 && sum_valid !== 1'b1; i++) @(negedge CLK_SYS);
    if (i == 5000) stuck("sum_valid");
    check("sum", sum, es);
    check("fail", fail, 1'b0);
    check("done busy halted", {done, busy, halted}, 3'h4);
  endtask

  // full session: password compare, junk before the start mark, one data record
  task automatic s_full;
    check("rate", link_rate, 8'h28);
    session(1'b0, 8'h03, {8'h11, 8'h3a, 8'h02, 8'h00, 8'h40, 8'h00, 8'haa, 8'h55, 8'hbf,
            8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff}, 16'h00ff);
    check("rate", link_rate, 8'h18);
    check("writes", wq.size(), 2);
    check("wr0", wq[0], 24'h0040aa);
    check("wr1", wq[1], 24'h004155);
  endtask

  // second command at the kept rate on a blank part, no password sent
  task automatic s_again;
    blank = 1'b1;
    session(1'b1, 8'h00, {8'h3a, 8'h01, 8'h00, 8'h50, 8'h00, 8'h80, 8'h2f,
            8'h3a, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff}, 16'h0080);
    check("wr2", wq[2], 24'h005080);
    check("rate", link_rate, 8'h18);
    check("updates", n_upd, 1);
  endtask

  // direct byte to the second device; the released data line shows the inverse
  task automatic tx(input logic [7:0] d, input logic e);
    int i;
    @(negedge CLK_SYS);
    link_b.h2d_valid = 1'b1;
    link_b.h2d_data = d;
    link_b.h2d_err = e;
    for (i = 0; i < 200 && link_b.h2d_ready !== 1'b1; i++) @(negedge CLK_SYS);
    if (i == 200) stuck("h2d_ready");
    @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    link_b.h2d_valid = 1'b0;
    link_b.h2d_data = ~d;
    link_b.h2d_err = 1'b0;
  endtask

  task automatic rx(input logic [7:0] exp);
    int i;
    for (i = 0; i < 200 && link_b.d2h_valid !== 1'b1; i++) @(negedge CLK_SYS);
    if (i == 200) stuck("d2h_valid");
    check("reply", link_b.d2h_data, exp);
    @(negedge CLK_SYS);
  endtask

  // no reply for a while, then the halt flag as expected
  task automatic quiet(input logic h);
    int i, n;
    n = 0;
    for (i = 0; i < 20; i++) begin
      @(negedge CLK_SYS);
      n += (link_b.d2h_valid !== 1'b0);
    end
    check("silence", n, 0);
    check("halted", halted_b, h);
  endtask

  task automatic err_seq(input logic [7:0] code);
    for (int i = 0; i < 9; i++) rx(i < 3 ? 8'ha1 : i < 6 ? 8'ha3 : code);
    quiet(1'b1);
  endtask

  task automatic reset_b;
    @(negedge CLK_SYS);
    rstn_b = 1'b0;
    repeat (2) @(negedge CLK_SYS);
    rstn_b = 1'b1;
    @(negedge CLK_SYS);
  endtask

  // reset the second device and get through matching, and through rate when rate is set
  task automatic sync_b(input logic rate);
    reset_b;
    tx(8'h5a, 1'b0);
    rx(8'h5a);
    if (rate) tx(8'h18, 1'b0);
    if (rate) rx(8'h18);
  endtask

  task automatic open_b(input logic [7:0] cnt_lo);
    sync_b(1'b1);
    tx(8'h30, 1'b0);
    rx(8'h30);
    tx(8'h00, 1'b0);
    tx(cnt_lo, 1'b0);
    tx(8'h00, 1'b0);
    tx(8'h20, 1'b0);
  endtask

  task automatic s_nomatch;
    reset_b;
    tx(8'h11, 1'b0);
    tx(8'h5a, 1'b1);
    quiet(1'b0);
    tx(8'h5a, 1'b0);
    rx(8'h5a);
  endtask

  // bad rate while the receiver stalls: the buffer must keep every code byte
  task automatic s_bad_rate;
    sync_b(1'b0);
    link_b.d2h_ready = 1'b0;
    tx(8'h77, 1'b0);
    repeat (30) @(negedge CLK_SYS);
    link_b.d2h_ready = 1'b1;
    err_seq(8'h62);
    tx(8'h5a, 1'b0);
    quiet(1'b1);
  endtask

  task automatic s_bad_cmd;
    sync_b(1'b1);
    tx(8'h31, 1'b0);
    err_seq(8'h63);
  endtask

  task automatic s_prot;
    prot_b = 1'b1;
    sync_b(1'b1);
    tx(8'h30, 1'b0);
    quiet(1'b1);
    prot_b = 1'b0;
  endtask

  task automatic s_addr_err;
    sync_b(1'b1);
    tx(8'h30, 1'b0);
    rx(8'h30);
    tx(8'h00, 1'b0);
    tx(8'h10, 1'b1);
    quiet(1'b1);
  endtask

  task automatic s_pw_bad;
    open_b(8'h10);
    tx(8'h31, 1'b0);
    tx(8'h32, 1'b0);
    quiet(1'b0);
    tx(8'h00, 1'b0);
    quiet(1'b1);
  endtask

  task automatic s_blank_bad;
    blank_b = 1'b1;
    open_b(8'h11);
    quiet(1'b1);
  endtask

  task automatic s_bad_rec;
    open_b(8'h10);
    tx(8'h3a, 1'b0);
    tx(8'h01, 1'b0);
    tx(8'h00, 1'b0);
    tx(8'h00, 1'b0);
    quiet(1'b0);
    tx(8'h02, 1'b0);
    quiet(1'b1);
    blank_b = 1'b0;
  endtask

  // reset for ten cycles, then every scenario in turn
  initial begin
    link_b.h2d_valid = 1'b0;
    link_b.h2d_data = 8'h00;
    link_b.h2d_err = 1'b0;
    link_b.d2h_ready = 1'b1;
    repeat (10) @(negedge CLK_SYS);
    RSTN = 1'b1;
    rstn_b = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    s_full;
    s_again;
    s_nomatch;
    s_bad_rate;
    s_bad_cmd;
    s_prot;
    s_addr_err;
    s_pw_bad;
    s_blank_bad;
    s_bad_rec;
    test_done;
  end
endmodule
